/* File: hdl/backlight_i2c_register_interface.sv */
// Functional notes
// - target answers at 7-bit address 0x2A or 0x2B, picked by mode resistor
// - write: address+W, register address, two value bytes
// - read: address+W, register address, address+R, two value bytes returned
// - configuration writes accepted in every operating state
// - device works without any serial access, from pins and resistors
// - alert pin asserts whenever an enabled fault flag is set and the global enable is on
// - fault flags in three readable registers: supply, boost, led
// - flag clears only when status and clear bits both written one
// - enabled fault reads its two-bit enable field as 2b'10
// - writing 2b'01 disables a fault's alert, 2b'11 enables it
// - global enable off keeps every fault off the alert pin
// - most fault enables are on after reset
// - diagnostic field shows live functional state code
// - pwm input duty measured and readable as 16-bit value
// - produced led pwm duty readable as 16-bit value
// - produced led current dac setting readable as 12-bit value
// - adaptive boost target readable as 10-bit value
// - resistor detection results readable as diagnostics
// - registers at even offsets 00h..1Eh, others reserved
// - brightness register holds 16-bit value, reset 0h
// - dither field adds up to 3 bits of pwm resolution
// - source field picks pwm pin or brightness register
// - source field 0h means brightness follows the pwm pin
// - bus open 500 ms without stop sets i2c error flag
`timescale 1ns/1ps
module backlight_i2c_register_interface #(
	parameter longint TIMEOUT_CYCLES = backlight_regs_pkg::I2C_TIMEOUT_CYCLES
) (
	input wire logic ref_clk, // device clock
	input wire logic rst, // async reset, active high
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output backlight_regs_pkg::od_pin_t sda_drv, // data pin pull-down and enable
	input wire logic addr_select, // mode resistor picks upper address
	input wire logic pwm_in, // pwm brightness pin
	input wire logic [3:0] supply_fault_evt, // supply fault detections
	input wire logic [3:0] boost_fault_evt, // boost fault detections
	input wire logic [3:0] led_fault_evt, // led fault detections
	input wire logic [3:0] current_state_code, // functional state machine state
	input wire logic [9:0] boost_target_value, // adaptive boost target
	input backlight_regs_pkg::detect_t detect_results, // resistor detection results
	output logic fault_alert_n, // alert to host, low when active
	output logic [15:0] output_duty_value, // led pwm duty in use
	output logic [11:0] current_dac_value, // led current dac in use
	output logic [2:0] ramp_duration_select, // brightness ramp duration
	output logic s_curve_ramp_on, // s-shape ramp smoothing
	output logic [1:0] spectrum_spread_rate // spread modulation rate
);
	import backlight_regs_pkg::*;

	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] pwm_sync_reg;
	logic scl_reg;
	logic sda_reg;
	logic pwm_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	i2c_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic [7:0] wr_hi_reg;
	logic [1:0] byte_idx_reg;
	logic rw_reg;
	logic nack_reg;
	logic wr_pulse_reg;
	logic [15:0] wr_data_reg;
	logic bus_open_reg;
	logic [31:0] open_cnt_reg;
	logic timeout_reg;
	logic [15:0] brightness_level_reg;
	logic [15:0] led_current_level_reg;
	logic [15:0] user_setup_one_reg;
	logic [15:0] user_setup_two_reg;
	logic [FAULT_GROUPS-1:0][FAULTS_PER_GROUP-1:0] en_reg;
	logic global_en_reg;
	logic [FAULT_GROUPS-1:0][FAULTS_PER_GROUP-1:0] flag_reg;
	logic [FAULT_GROUPS-1:0][FAULTS_PER_GROUP-1:0] fault_evt;
	logic [PWM_WINDOW_BITS-1:0] win_cnt_reg;
	logic [PWM_WINDOW_BITS-1:0] high_cnt_reg;
	logic [PWM_WINDOW_BITS-1:0] pwm_duty_reg;
	logic [15:0] duty_next;
	logic [15:0] rd_word;
	logic [6:0] own_addr;
	logic [1:0] brightness_source_select;
	logic [2:0] dither_select;

	// register address to register word index, or -1 when unmapped
	function automatic int reg_index(input logic [7:0] a);
		if (a[0] == 1'b0 && a <= OFS_LAST)
			return int'(a[7:1]);
		return -1;
	endfunction : reg_index

	// 2-bit enable field read value per fault
	function automatic logic [1:0] en_field(input logic en);
		return en ? EN_READ_ON : EN_READ_OFF;
	endfunction : en_field

	// clear the low pwm bits that the chosen dither depth does not reach
	function automatic logic [15:0] apply_dither(input logic [15:0] v, input logic [2:0] d);
		logic [2:0] dd;
		dd = (d > DITHER_MAX) ? DITHER_MAX : d;
		return v & (16'hffff << (DITHER_MAX - dd));
	endfunction : apply_dither

	// enable register word for one group, global enable in the supply word
	function automatic logic [15:0] en_word(input logic [3:0] en, input logic glb, input logic top);
		logic [15:0] w;
		w = 16'h0000;
		for (int k = 0; k < FAULTS_PER_GROUP; k++)
			w[2*k +: 2] = en_field(en[k]);
		if (top)
			w[GLOBAL_EN_HI:GLOBAL_EN_LO] = en_field(glb);
		return w;
	endfunction : en_word

	// status word: flag at odd bit, paired clear bit reads zero
	function automatic logic [15:0] flag_word(input logic [3:0] f);
		logic [15:0] w;
		w = 16'h0000;
		for (int k = 0; k < FAULTS_PER_GROUP; k++)
			w[2*k+1] = f[k];
		return w;
	endfunction : flag_word

	// read mux over the register map
	function automatic logic [15:0] read_word(input logic [7:0] a);
		logic [15:0] w;
		w = 16'h0000;
		unique case (a)
			OFS_BRIGHTNESS_LEVEL: w = brightness_level_reg;
			OFS_LED_CURRENT_LEVEL: w = led_current_level_reg;
			OFS_USER_SETUP_ONE: w = user_setup_one_reg;
			OFS_USER_SETUP_TWO: w = user_setup_two_reg;
			OFS_SUPPLY_ALERT_ENABLES: w = en_word(en_reg[GRP_SUPPLY], global_en_reg, 1'b1);
			OFS_BOOST_ALERT_ENABLES: w = en_word(en_reg[GRP_BOOST], 1'b0, 1'b0);
			OFS_LED_ALERT_ENABLES: w = en_word(en_reg[GRP_LED], 1'b0, 1'b0);
			OFS_SUPPLY_FAULT_FLAGS: w = flag_word(flag_reg[GRP_SUPPLY]);
			OFS_BOOST_FAULT_FLAGS: w = flag_word(flag_reg[GRP_BOOST]);
			OFS_LED_FAULT_FLAGS: w = flag_word(flag_reg[GRP_LED]);
			OFS_STATE_MACHINE_DIAG: w = {12'h000, current_state_code};
			OFS_PWM_INPUT_DIAG: w = pwm_duty_reg;
			OFS_PWM_OUTPUT_DIAG: w = output_duty_value;
			OFS_LED_CURRENT_DIAG: w = {4'h0, current_dac_value};
			OFS_ADAPTIVE_BOOST_DIAG: w = {6'h00, boost_target_value};
			OFS_AUTODETECT_DIAG: w = {5'h00, detect_results};
			default: w = 16'h0000;
		endcase
		return w;
	endfunction : read_word

	// word at the register pointer, source of read data
	always_comb
		rd_word = read_word(ptr_reg);

	// three-flop pin synchronisers, a change counts once stages two and three agree
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			pwm_sync_reg <= 3'h0;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			pwm_reg <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			pwm_sync_reg <= {pwm_sync_reg[1:0], pwm_in};
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_reg <= sda_sync_reg[2];
			if (pwm_sync_reg[1] == pwm_sync_reg[2])
				pwm_reg <= pwm_sync_reg[2];
			scl_prev_reg <= scl_reg;
			sda_prev_reg <= sda_reg;
		end
	end

	// bus events
	assign scl_rise = scl_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_reg & scl_prev_reg;
	assign start_det = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
	assign stop_det = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
	assign own_addr = addr_select ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;

	// open-bus watchdog: start opens, stop closes, 500 ms open sets the error
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_open_reg <= 1'b0;
			open_cnt_reg <= 32'h0;
			timeout_reg <= 1'b0;
		end
		else
		begin
			timeout_reg <= 1'b0;
			if (start_det)
			begin
				bus_open_reg <= 1'b1;
				open_cnt_reg <= 32'h0;
			end
			else if (stop_det)
				bus_open_reg <= 1'b0;
			else if (bus_open_reg)
			begin
				if (open_cnt_reg >= 32'(TIMEOUT_CYCLES - 1))
				begin
					bus_open_reg <= 1'b0;
					timeout_reg <= 1'b1;
				end
				else
					open_cnt_reg <= open_cnt_reg + 32'h1;
			end
		end
	end

	// serial target state machine: bits sampled on scl rise, driven after scl fall
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			wr_hi_reg <= 8'h00;
			byte_idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			wr_pulse_reg <= 1'b0;
			wr_data_reg <= 16'h0000;
			sda_drv <= '0;
		end
		else
		begin
			wr_pulse_reg <= 1'b0;
			if (start_det)
			begin
				state_reg <= ST_ADDR; // repeated start lands here too
				bit_cnt_reg <= 4'h0;
				sda_drv <= '0;
			end
			else if (stop_det || timeout_reg)
			begin
				state_reg <= ST_IDLE;
				sda_drv <= '0;
			end
			else if (scl_rise)
			begin
				unique case (state_reg)
					ST_ADDR, ST_REG, ST_WR:
					begin
						shift_reg <= {shift_reg[6:0], sda_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					ST_RD: bit_cnt_reg <= bit_cnt_reg + 4'h1;
					ST_RD_ACK: nack_reg <= sda_reg;
					default: ;
				endcase
			end
			else if (scl_fall)
			begin
				unique case (state_reg)
					ST_ADDR:
						if (bit_cnt_reg == 4'h8)
						begin
							if (shift_reg[7:1] == own_addr)
							begin
								state_reg <= ST_ADDR_ACK;
								rw_reg <= shift_reg[0];
								sda_drv <= '{out: 1'b0, oe: 1'b1};
							end
							else
								state_reg <= ST_IDLE;
						end
					ST_ADDR_ACK:
					begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg)
						begin
							state_reg <= ST_RD;
							tx_reg <= rd_word[15:8];
							byte_idx_reg <= 2'h0;
							sda_drv <= '{out: 1'b0, oe: ~rd_word[15]};
						end
						else
						begin
							state_reg <= ST_REG;
							sda_drv <= '0;
						end
					end
					ST_REG:
						if (bit_cnt_reg == 4'h8)
						begin
							state_reg <= ST_REG_ACK;
							ptr_reg <= shift_reg;
							sda_drv <= '{out: 1'b0, oe: 1'b1};
						end
					ST_REG_ACK:
					begin
						state_reg <= ST_WR;
						bit_cnt_reg <= 4'h0;
						byte_idx_reg <= 2'h0;
						sda_drv <= '0;
					end
					ST_WR:
						if (bit_cnt_reg == 4'h8)
						begin
							state_reg <= ST_WR_ACK;
							sda_drv <= '{out: 1'b0, oe: 1'b1};
							if (byte_idx_reg == 2'h0)
								wr_hi_reg <= shift_reg;
							else if (byte_idx_reg == 2'h1)
							begin
								wr_data_reg <= {wr_hi_reg, shift_reg};
								wr_pulse_reg <= 1'b1;
							end
						end
					ST_WR_ACK:
					begin
						state_reg <= ST_WR;
						bit_cnt_reg <= 4'h0;
						sda_drv <= '0;
						if (byte_idx_reg != 2'h2)
							byte_idx_reg <= byte_idx_reg + 2'h1;
					end
					ST_RD:
						if (bit_cnt_reg == 4'h8)
						begin
							state_reg <= ST_RD_ACK;
							sda_drv <= '0;
						end
						else
						begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							sda_drv <= '{out: 1'b0, oe: ~tx_reg[6]};
						end
					ST_RD_ACK:
						if (nack_reg)
							state_reg <= ST_IDLE;
						else
						begin
							state_reg <= ST_RD;
							bit_cnt_reg <= 4'h0;
							// second byte is the low half, later bytes read 80h (first bit released, rest pulled low)
							tx_reg <= (byte_idx_reg == 2'h0) ? rd_word[7:0] : 8'h00;
							sda_drv <= '{out: 1'b0,
								oe: (byte_idx_reg == 2'h0) ? ~rd_word[7] : 1'b0};
							byte_idx_reg <= 2'h1;
						end
					default: ;
				endcase
			end
		end
	end

	// configuration registers, writable whatever the functional state
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			brightness_level_reg <= RST_BRIGHTNESS_LEVEL;
			led_current_level_reg <= RST_LED_CURRENT_LEVEL;
			user_setup_one_reg <= RST_USER_SETUP_ONE;
			user_setup_two_reg <= RST_USER_SETUP_TWO;
		end
		else if (wr_pulse_reg)
		begin
			unique case (ptr_reg)
				OFS_BRIGHTNESS_LEVEL: brightness_level_reg <= wr_data_reg;
				OFS_LED_CURRENT_LEVEL: led_current_level_reg <= wr_data_reg;
				OFS_USER_SETUP_ONE: user_setup_one_reg <= wr_data_reg;
				OFS_USER_SETUP_TWO: user_setup_two_reg <= wr_data_reg;
				default: ;
			endcase
		end
	end

	// alert enables: 01 turns a fault off, 11 on, other codes leave it
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			en_reg[GRP_SUPPLY] <= RST_SUPPLY_EN;
			en_reg[GRP_BOOST] <= RST_BOOST_EN;
			en_reg[GRP_LED] <= RST_LED_EN;
			global_en_reg <= RST_GLOBAL_EN;
		end
		else if (wr_pulse_reg)
		begin
			for (int g = 0; g < FAULT_GROUPS; g++)
				if (reg_index(ptr_reg) == reg_index(OFS_SUPPLY_ALERT_ENABLES) + g)
					for (int k = 0; k < FAULTS_PER_GROUP; k++)
					begin
						if (wr_data_reg[2*k +: 2] == EN_WRITE_OFF)
							en_reg[g][k] <= 1'b0;
						else if (wr_data_reg[2*k +: 2] == EN_WRITE_ON)
							en_reg[g][k] <= 1'b1;
					end
			if (ptr_reg == OFS_SUPPLY_ALERT_ENABLES)
			begin
				if (wr_data_reg[GLOBAL_EN_HI:GLOBAL_EN_LO] == EN_WRITE_OFF)
					global_en_reg <= 1'b0;
				else if (wr_data_reg[GLOBAL_EN_HI:GLOBAL_EN_LO] == EN_WRITE_ON)
					global_en_reg <= 1'b1;
			end
		end
	end

	// fault events per group, the i2c timeout joins the supply group
	assign fault_evt[GRP_SUPPLY] = supply_fault_evt | (4'(timeout_reg) << I2C_ERROR_FAULT);
	assign fault_evt[GRP_BOOST] = boost_fault_evt;
	assign fault_evt[GRP_LED] = led_fault_evt;

	// sticky fault flags: clear needs status and clear bit both one, a new event wins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			flag_reg <= '0;
		else
			for (int g = 0; g < FAULT_GROUPS; g++)
				for (int k = 0; k < FAULTS_PER_GROUP; k++)
					if (fault_evt[g][k])
						flag_reg[g][k] <= 1'b1;
					else if (wr_pulse_reg
						&& reg_index(ptr_reg) == reg_index(OFS_SUPPLY_FAULT_FLAGS) + g
						&& wr_data_reg[2*k+1] && wr_data_reg[2*k])
						flag_reg[g][k] <= 1'b0;
	end

	// alert pin: any enabled flag while the global enable is on
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			fault_alert_n <= 1'b1;
		else
			fault_alert_n <= ~(global_en_reg && |(flag_reg & en_reg));
	end

	// pwm input duty: high samples counted over a 2^16-cycle window
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			win_cnt_reg <= '0;
			high_cnt_reg <= '0;
			pwm_duty_reg <= '0;
		end
		else
		begin
			win_cnt_reg <= win_cnt_reg + 16'h1;
			if (win_cnt_reg == '1)
			begin
				// saturate so a pin held high reads full scale, not zero
				pwm_duty_reg <= (&high_cnt_reg) ? high_cnt_reg : high_cnt_reg + 16'(pwm_reg);
				high_cnt_reg <= '0;
			end
			else
				high_cnt_reg <= high_cnt_reg + 16'(pwm_reg);
		end
	end

	// brightness source and dither pick the produced duty
	assign brightness_source_select = user_setup_one_reg[SRC_SEL_HI:SRC_SEL_LO];
	assign dither_select = user_setup_one_reg[DITHER_HI:DITHER_LO];
	always_comb
	begin
		if (brightness_source_select == SRC_PWM_PIN)
			duty_next = apply_dither(pwm_duty_reg, dither_select);
		else
			duty_next = apply_dither(brightness_level_reg, dither_select);
	end

	// produced duty and current, steered by registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			output_duty_value <= 16'h0000;
			current_dac_value <= 12'h000;
			ramp_duration_select <= 3'h0;
			s_curve_ramp_on <= 1'b0;
			spectrum_spread_rate <= 2'h0;
		end
		else
		begin
			output_duty_value <= duty_next;
			current_dac_value <= led_current_level_reg[DAC_BITS-1:0];
			ramp_duration_select <= user_setup_one_reg[7:5];
			s_curve_ramp_on <= user_setup_one_reg[1];
			spectrum_spread_rate <= user_setup_one_reg[13:12];
		end
	end

endmodule : backlight_i2c_register_interface

/* File: hdl/backlight_regs_pkg.sv */
package backlight_regs_pkg;

	// register offsets (8-bit register address)
	localparam logic [7:0] OFS_BRIGHTNESS_LEVEL = 8'h00;
	localparam logic [7:0] OFS_LED_CURRENT_LEVEL = 8'h02;
	localparam logic [7:0] OFS_USER_SETUP_ONE = 8'h04;
	localparam logic [7:0] OFS_USER_SETUP_TWO = 8'h06;
	localparam logic [7:0] OFS_SUPPLY_ALERT_ENABLES = 8'h08;
	localparam logic [7:0] OFS_BOOST_ALERT_ENABLES = 8'h0a;
	localparam logic [7:0] OFS_LED_ALERT_ENABLES = 8'h0c;
	localparam logic [7:0] OFS_SUPPLY_FAULT_FLAGS = 8'h0e;
	localparam logic [7:0] OFS_BOOST_FAULT_FLAGS = 8'h10;
	localparam logic [7:0] OFS_LED_FAULT_FLAGS = 8'h12;
	localparam logic [7:0] OFS_STATE_MACHINE_DIAG = 8'h14;
	localparam logic [7:0] OFS_PWM_INPUT_DIAG = 8'h16;
	localparam logic [7:0] OFS_PWM_OUTPUT_DIAG = 8'h18;
	localparam logic [7:0] OFS_LED_CURRENT_DIAG = 8'h1a;
	localparam logic [7:0] OFS_ADAPTIVE_BOOST_DIAG = 8'h1c;
	localparam logic [7:0] OFS_AUTODETECT_DIAG = 8'h1e;
	localparam logic [7:0] OFS_LAST = 8'h1e;

	// reset values
	localparam logic [15:0] RST_BRIGHTNESS_LEVEL = 16'h0000;
	localparam logic [15:0] RST_LED_CURRENT_LEVEL = 16'h0fff;
	localparam logic [15:0] RST_USER_SETUP_ONE = 16'h08a3;
	localparam logic [15:0] RST_USER_SETUP_TWO = 16'h0000;
	// per group: fault enabled after reset (led fault 3 starts disabled)
	localparam logic [3:0] RST_SUPPLY_EN = 4'hf;
	localparam logic [3:0] RST_BOOST_EN = 4'hf;
	localparam logic [3:0] RST_LED_EN = 4'h7;
	localparam logic RST_GLOBAL_EN = 1'b1;

	// i2c target addresses
	localparam logic [6:0] TARGET_ADDR_LOW = 7'h2a;
	localparam logic [6:0] TARGET_ADDR_HIGH = 7'h2b;

	// field layout
	localparam int FAULTS_PER_GROUP = 4;
	localparam int FAULT_GROUPS = 3;
	localparam int GRP_SUPPLY = 0;
	localparam int GRP_BOOST = 1;
	localparam int GRP_LED = 2;
	localparam int I2C_ERROR_FAULT = 3; // supply group slot of the i2c timeout
	localparam int GLOBAL_EN_HI = 15;
	localparam int GLOBAL_EN_LO = 14;
	localparam int SRC_SEL_HI = 9;
	localparam int SRC_SEL_LO = 8;
	localparam int DITHER_HI = 4;
	localparam int DITHER_LO = 2;
	localparam logic [1:0] SRC_PWM_PIN = 2'h0;
	localparam logic [1:0] EN_READ_ON = 2'b10;
	localparam logic [1:0] EN_READ_OFF = 2'b00;
	localparam logic [1:0] EN_WRITE_OFF = 2'b01;
	localparam logic [1:0] EN_WRITE_ON = 2'b11;
	localparam logic [2:0] DITHER_MAX = 3'h3;
	localparam int DAC_BITS = 12;

	// timing
	localparam longint CLK_KHZ = 125000;
	localparam longint I2C_TIMEOUT_MS = 500;
	localparam longint I2C_TIMEOUT_CYCLES = I2C_TIMEOUT_MS * CLK_KHZ; // longest time
	localparam int PWM_WINDOW_BITS = 16;

	// resistor detection results
	typedef struct packed {
		logic [1:0] dim_mode;
		logic [2:0] detected_string_phasing;
		logic [2:0] detected_switch_rate;
		logic [2:0] detected_dim_rate;
	} detect_t;

	// open-drain data pin
	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
	} i2c_state_t;

endpackage : backlight_regs_pkg

/* File: verification/backlight_chk.sv */
`timescale 1ns/1ps
module backlight_chk (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic scl_in, // clock pin
	input wire logic sda_in, // data wire
	input backlight_regs_pkg::od_pin_t sda_drv, // data pull
	input wire logic [3:0] supply_fault_evt, // faults
	input wire logic [3:0] boost_fault_evt, // faults
	input wire logic [3:0] led_fault_evt, // faults
	input wire logic fault_alert_n, // alert
	input wire logic [11:0] current_dac_value, // dac
	input wire logic [2:0] ramp_duration_select, // ramp
	input wire logic s_curve_ramp_on, // smoothing
	input wire logic [1:0] spectrum_spread_rate // spread
);
	import backlight_regs_pkg::*;
	logic scl_q, sda_q, bus_open, any_evt;
	logic [3:0] cyc;
	assign any_evt = |{supply_fault_evt, boost_fault_evt, led_fault_evt};
	// frame state seen on the pins, cycles since reset
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			{scl_q, sda_q, bus_open, cyc} <= 7'h60;
		else
		begin
			{scl_q, sda_q} <= {scl_in, sda_in};
			if (scl_in && scl_q && sda_q != sda_in)
				bus_open <= sda_q;
			if (cyc != 4'hf)
				cyc <= cyc + 4'h1;
		end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_idle8;
		!bus_open [*8];
	endsequence
	sequence s_scl_high8;
		scl_in [*8];
	endsequence
	chk_sda_pull_only: assert property (sda_drv.out == 1'b0)
		else $error("data pin driven high");
	chk_oe_idle_free: assert property (s_idle8 |-> !sda_drv.oe)
		else $error("data pulled on idle bus");
	chk_oe_scl_high: assert property (s_scl_high8 |-> $stable(sda_drv.oe))
		else $error("data pull moved with clock high");
	chk_alert_cause: assert property ($fell(fault_alert_n) |-> bus_open || $past(any_evt, 2))
		else $error("alert without fault or write");
	chk_alert_release: assert property ($rose(fault_alert_n) |-> bus_open)
		else $error("alert released without write");
	chk_dac_reset: assert property (cyc >= 4'h2 && cyc <= 4'h6 |-> current_dac_value == 12'hfff)
		else $error("dac not at reset value");
	chk_setup_reset: assert property (cyc >= 4'h2 && cyc <= 4'h6 |->
		ramp_duration_select == 3'h5 && s_curve_ramp_on && spectrum_spread_rate == 2'h0)
		else $error("setup outputs not at reset value");
	chk_dac_quiet: assert property (cyc == 4'hf && !bus_open |-> $stable(current_dac_value))
		else $error("dac moved without bus traffic");
endmodule : backlight_chk
bind backlight_i2c_register_interface backlight_chk u_chk (.ref_clk, .rst, .scl_in, .sda_in,
	.sda_drv, .supply_fault_evt, .boost_fault_evt, .led_fault_evt, .fault_alert_n,
	.current_dac_value, .ramp_duration_select, .s_curve_ramp_on, .spectrum_spread_rate);

/* File: verification/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
	output logic scl, // serial clock, idles high
	output logic sda_pull, // high pulls the data wire low
	input wire logic sda // resolved data wire
);
	localparam time Q = 20;
	logic [7:0] rx;
	logic a0, a1, a2, a3;
	// bus released between frames
	initial
		{scl, sda_pull} = 2'b10;
	// start (0,1) or stop (1,0); phase kept clear of device clock edges
	task automatic bus_cond(input logic a, input logic b);
		#(11 - $time % 8);
		scl = 1'b0;
		#Q sda_pull = a;
		#Q scl = 1'b1;
		#Q sda_pull = b;
		#Q;
	endtask : bus_cond
	// one clock period on the bus
	task automatic slot(input logic pull, output logic seen);
		scl = 1'b0;
		#Q sda_pull = pull;
		#Q scl = 1'b1;
		#Q seen = sda;
		#Q;
	endtask : slot
	// one byte msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] got,
		output logic ack);
		logic nack;
		for (int i = 7; i >= 0; i--)
			slot(!tx[i], got[i]);
		slot(mack, nack);
		ack = !nack;
	endtask : xfer
	// register write or read: offset first, value high byte then low byte
	task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic rd_op,
		input logic [15:0] wv, output logic [15:0] rv, output logic ok);
		bus_cond(1'b0, 1'b1);
		xfer({dev, 1'b0}, 1'b0, rx, a0);
		xfer(ofs, 1'b0, rx, a1);
		a2 = 1'b1;
		if (rd_op)
		begin
			bus_cond(1'b0, 1'b1);
			xfer({dev, 1'b1}, 1'b0, rx, a2);
			wv = 16'hffff;
		end
		xfer(wv[15:8], rd_op, rv[15:8], a3);
		xfer(wv[7:0], 1'b0, rv[7:0], a3);
		bus_cond(1'b1, 1'b0);
		ok = a0 && a1 && a2 && (rd_op || a3);
	endtask : access
	// frame left open with the clock held low
	task automatic open_bus(input logic [6:0] dev);
		bus_cond(1'b0, 1'b1);
		xfer({dev, 1'b0}, 1'b0, rx, a0);
		scl = 1'b0;
	endtask : open_bus
endmodule : i2c_host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import backlight_regs_pkg::*;
	localparam longint TO = 2000;
	logic ref_clk, rst, scl_in, sda_in, host_pull, addr_select, pwm_in, fault_alert_n;
	logic [11:0] evt, dac;
	logic [3:0] state_code;
	logic [9:0] boost_tgt;
	logic [15:0] v, rd, duty;
	logic [6:0] dev;
	logic [2:0] ramp;
	logic [1:0] spread;
	logic s_curve, ok;
	detect_t det;
	od_pin_t sda_drv;
	int bad_count, comparisons;
	// open-drain data wire
	assign sda_in = !(host_pull || sda_drv.oe);
	backlight_i2c_register_interface #(.TIMEOUT_CYCLES(TO)) u_dut (.ref_clk, .rst, .scl_in,
		.sda_in, .sda_drv, .addr_select, .pwm_in, .supply_fault_evt(evt[3:0]),
		.boost_fault_evt(evt[7:4]), .led_fault_evt(evt[11:8]), .current_state_code(state_code),
		.boost_target_value(boost_tgt), .detect_results(det), .fault_alert_n,
		.output_duty_value(duty), .current_dac_value(dac), .ramp_duration_select(ramp),
		.s_curve_ramp_on(s_curve), .spectrum_spread_rate(spread));
	i2c_host_model u_host (.scl(scl_in), .sda_pull(host_pull), .sda(sda_in));
	// device clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// pwm pin wanders at random
	always @(negedge ref_clk)
		pwm_in <= 1'($urandom);
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// enable word as read back: 10 per enabled fault
	function automatic logic [15:0] en_rd(input logic [3:0] en, input logic g);
		en_rd = {g, 15'h0};
		for (int k = 0; k < 4; k++)
			en_rd[2*k+1] = en[k];
	endfunction : en_rd
	// produced duty from the register: bits below the dither depth read zero
	function automatic logic [15:0] duty_exp(input logic [15:0] b, input logic [2:0] d);
		duty_exp = (d > 3'h3) ? b : b & (16'hffff << (3 - d));
	endfunction : duty_exp
	task automatic wr(input logic [7:0] ofs, input logic [15:0] wv);
		u_host.access(dev, ofs, 1'b0, wv, rd, ok);
		cmp("write ack", 16'h1, {15'h0, ok});
	endtask : wr
	task automatic rdc(input logic [7:0] ofs, input logic [15:0] e);
		u_host.access(dev, ofs, 1'b1, 16'h0, rd, ok);
		cmp("read ack", 16'h1, {15'h0, ok});
		cmp($sformatf("register %h", ofs), e, rd);
	endtask : rdc
	task automatic al(input logic e);
		repeat (3) @(negedge ref_clk);
		cmp("alert pin", {15'h0, e}, {15'h0, fault_alert_n});
	endtask : al
	task automatic fire(input logic [11:0] m, input logic e);
		@(negedge ref_clk);
		evt = m;
		@(negedge ref_clk);
		evt = 12'h0;
		al(e);
	endtask : fire
	// hang guard
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		bad_count++;
		complete_run();
	end
	initial
	begin
		{rst, addr_select, evt, state_code, boost_tgt, det} = {1'b1, 38'h0};
		bad_count = 0;
		comparisons = 0;
		dev = 7'h2a;
		v = 16'($urandom(32'heab95dfd));
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (10) @(negedge ref_clk);
		// reset values and enable read coding
		rdc(8'h00, 16'h0000);
		rdc(8'h02, 16'h0fff);
		rdc(8'h04, 16'h08a3);
		rdc(8'h08, en_rd(4'hf, 1'b1));
		rdc(8'h0a, en_rd(4'hf, 1'b0));
		rdc(8'h0c, en_rd(4'h7, 1'b0));
		rdc(8'h12, 16'h0000);
		wr(8'h00, 16'hffff);
		rdc(8'h18, 16'h0000);
		rdc(8'h16, 16'h0000);
		// random values through registers and diagnostics
		repeat (3)
		begin
			@(negedge ref_clk);
			state_code = 4'($urandom);
			boost_tgt = 10'($urandom);
			det = detect_t'(11'($urandom));
			v = 16'($urandom);
			wr(8'h00, v);
			rdc(8'h00, v);
			wr(8'h02, v);
			cmp("dac pins", {4'h0, v[11:0]}, {4'h0, dac});
			rdc(8'h1a, {4'h0, v[11:0]});
			rdc(8'h14, {12'h0, state_code});
			rdc(8'h1c, {6'h0, boost_tgt});
			rdc(8'h1e, {5'h0, det});
			wr(8'h04, v | 16'h0100);
			cmp("setup", {10'h0, v[13:12], v[7:5], v[1]}, {10'h0, spread, ramp, s_curve});
			rdc(8'h18, duty_exp(v, v[4:2]));
			cmp("duty pins", duty_exp(v, v[4:2]), duty);
		end
		wr(8'h14, 16'hffff);
		rdc(8'h14, {12'h0, state_code});
		wr(8'h20, 16'hffff);
		rdc(8'h20, 16'h0000);
		rdc(8'h03, 16'h0000);
		// target address follows the mode resistor
		u_host.access(7'h2c, 8'h00, 1'b0, 16'hffff, rd, ok);
		cmp("stray ack", 16'h0, {15'h0, ok});
		@(negedge ref_clk);
		addr_select = 1'b1;
		u_host.access(7'h2a, 8'h00, 1'b0, 16'hffff, rd, ok);
		cmp("stray ack", 16'h0, {15'h0, ok});
		dev = 7'h2b;
		wr(8'h00, 16'h5a5a);
		rdc(8'h00, 16'h5a5a);
		// fault flags, clear handshake, enables
		fire(12'h001, 1'b0);
		rdc(8'h0e, 16'h0002);
		wr(8'h0e, 16'h0002);
		wr(8'h0e, 16'h0001);
		rdc(8'h0e, 16'h0002);
		wr(8'h0e, 16'h0003);
		al(1'b1);
		wr(8'h08, 16'h0001);
		rdc(8'h08, 16'h80a8);
		fire(12'h001, 1'b1);
		wr(8'h08, 16'h0003);
		al(1'b0);
		wr(8'h0e, 16'h0003);
		wr(8'h08, 16'h4000);
		rdc(8'h08, 16'h00aa);
		fire(12'h820, 1'b1);
		rdc(8'h10, 16'h0008);
		rdc(8'h12, 16'h0080);
		wr(8'h08, 16'hc000);
		al(1'b0);
		wr(8'h10, 16'h000c);
		al(1'b1);
		wr(8'h12, 16'h00c0);
		// frame left open until the timeout
		u_host.open_bus(dev);
		repeat (TO + 50) @(negedge ref_clk);
		u_host.bus_cond(1'b1, 1'b0);
		rdc(8'h0e, 16'h0080);
		al(1'b0);
		wr(8'h0e, 16'h00c0);
		al(1'b1);
		complete_run();
	end
endmodule : testbench
